//--- src/cfes_pkg.sv
// package of the can frame sequencer and error state block
// assumes one core clock; shared by the frame sequencer and its checker
package cfes_pkg;
    localparam int CFES_STD_ID_W = 11;
    localparam int CFES_EXT_ID_W = 29;
    localparam int CFES_DLC_W = 4;
    localparam int CFES_MAX_BYTES = 8;
    localparam logic [3:0] CFES_DLC_MAX = 4'h0008;
    // descriptor layout: {ide, id, rtr, dlc, payload}
    localparam int CFES_PAY_LSB = 0;
    localparam int CFES_DLC_LSB = 64;
    localparam int CFES_RTR_POS = 68;
    localparam int CFES_ID_LSB = 69;
    localparam int CFES_IDE_POS = 98;
    localparam int CFES_DESC_W = 99;
    // error confinement
    localparam logic [8:0] CFES_TEC_RST = 9'h0000;
    localparam logic [7:0] CFES_REC_RST = 8'h0000;
    localparam logic [8:0] CFES_PASSIVE_TEC = 9'h0080;
    localparam logic [7:0] CFES_PASSIVE_REC = 8'h0080;
    localparam logic [8:0] CFES_BUSOFF_TEC = 9'h0100;
    localparam logic [8:0] CFES_TEC_MAX = 9'h01ff;
    localparam logic [7:0] CFES_REC_MAX = 8'h00ff;
    localparam logic [8:0] CFES_TX_ERR_STEP = 9'h0008;
    localparam logic [7:0] CFES_RX_ERR_STEP = 8'h0001;
    localparam logic [7:0] CFES_RX_SEVERE_STEP = 8'h0008;
    localparam logic [7:0] CFES_REC_RELOAD = 8'h0077;
    localparam logic [7:0] CFES_RECOVER_SEQS = 8'h0080;
    typedef enum logic [1:0] {
        CFES_ERR_ACTIVE = 2'h0,
        CFES_ERR_PASSIVE = 2'h1,
        CFES_BUS_OFF = 2'h2
    } cfes_err_state_t;
    typedef enum logic [3:0] {
        CFES_FLD_SOF = 4'h0,
        CFES_FLD_ARB = 4'h1,
        CFES_FLD_IDE = 4'h2,
        CFES_FLD_RTR = 4'h3,
        CFES_FLD_DLC = 4'h4,
        CFES_FLD_DATA = 4'h5,
        CFES_FLD_CRC = 4'h6,
        CFES_FLD_EOF = 4'h7
    } cfes_field_t;
    typedef enum logic [8:0] {
        CFES_ST_IDLE = 9'h001,
        CFES_ST_SOF = 9'h002,
        CFES_ST_ARB = 9'h004,
        CFES_ST_IDE = 9'h008,
        CFES_ST_RTR = 9'h010,
        CFES_ST_DLC = 9'h020,
        CFES_ST_DATA = 9'h040,
        CFES_ST_CRC = 9'h080,
        CFES_ST_EOF = 9'h100
    } cfes_state_t;
endpackage : cfes_pkg

//--- src/cfes_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes both sides are on mclk_i; ready and valid come from flops
`timescale 1ns/1ps
`default_nettype none
module cfes_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    initial begin
        if (WIDTH < 1) $error("cfes_buf2: WIDTH must be positive");
    end

    logic [WIDTH-1:0] slot0_ff, slot1_ff, nxt_slot0, nxt_slot1;
    logic [1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    always_comb begin
        push = in_valid_i && (cnt_ff != 2'h2);
        pop = out_ready_i && (cnt_ff != 2'h0);
        nxt_slot0 = slot0_ff;
        nxt_slot1 = slot1_ff;
        nxt_cnt = cnt_ff;
        if (pop) begin
            nxt_slot0 = slot1_ff;
        end
        if (push) begin
            if (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop)) begin
                nxt_slot0 = in_data_i;
            end else begin
                nxt_slot1 = in_data_i;
            end
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot0_ff <= '0;
            slot1_ff <= '0;
            cnt_ff <= 2'h0;
        end else begin
            slot0_ff <= nxt_slot0;
            slot1_ff <= nxt_slot1;
            cnt_ff <= nxt_cnt;
        end
    end

    assign in_ready_o = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o = slot0_ff;
endmodule : cfes_buf2
`default_nettype wire

//--- src/cfes_node.sv
// can frame sequencer and error confinement state of one node
// assumes requests and error events come from logic on mclk_i
`timescale 1ns/1ps
`default_nettype none
module cfes_node
    import cfes_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_ide_i,
    input wire logic [28:0] req_id_i,
    input wire logic req_rtr_i,
    input wire logic [3:0] req_dlc_i,
    input wire logic [63:0] req_data_i,
    output logic field_valid_o,
    input wire logic field_ready_i,
    output logic [3:0] field_kind_o,
    output logic [28:0] field_val_o,
    output logic frame_err_o,
    input wire logic tx_err_i,
    input wire logic tx_ok_i,
    input wire logic rx_err_i,
    input wire logic rx_err_severe_i,
    input wire logic rx_ok_i,
    input wire logic idle_seq_i,
    output logic [1:0] err_state_o,
    output logic [8:0] tec_o,
    output logic [7:0] rec_o
);
    logic buf_valid, buf_ready, buf_in_ready;
    logic [CFES_DESC_W-1:0] buf_data;
    logic req_ready_ff, nxt_req_ready, buf_push_valid;

    // the buffer only takes a word while the ready flop shows it, so no hidden push
    assign buf_push_valid = req_valid_i && req_ready_ff;

    cfes_buf2 #(.WIDTH(CFES_DESC_W)) u_buf (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(buf_push_valid),
        .in_ready_o(buf_in_ready),
        .in_data_i({req_ide_i, req_id_i, req_rtr_i, req_dlc_i, req_data_i}),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_ready),
        .out_data_o(buf_data)
    );

    // error counters
    logic [8:0] tec_ff, nxt_tec;
    logic [7:0] rec_ff, nxt_rec, seq_ff, nxt_seq;
    cfes_err_state_t est_ff, nxt_est;

    always_comb begin
        nxt_tec = tec_ff;
        nxt_rec = rec_ff;
        nxt_seq = seq_ff;
        nxt_est = est_ff;
        if (est_ff == CFES_BUS_OFF) begin
            // recovery needs 128 runs of 11 recessive bits
            if (idle_seq_i) begin
                nxt_seq = seq_ff + 8'h01;
            end
            if (idle_seq_i && (seq_ff + 8'h01 == CFES_RECOVER_SEQS)) begin
                nxt_tec = CFES_TEC_RST;
                nxt_rec = CFES_REC_RST;
                nxt_seq = 8'h00;
            end
        end else begin
            if (tx_err_i) begin
                nxt_tec = (tec_ff > CFES_TEC_MAX - CFES_TX_ERR_STEP) ? CFES_TEC_MAX : tec_ff + CFES_TX_ERR_STEP;
            end else if (tx_ok_i && tec_ff != 9'h000) begin
                nxt_tec = tec_ff - 9'h001;
            end
            if (rx_err_i) begin
                if (rx_err_severe_i) begin
                    nxt_rec = (rec_ff > CFES_REC_MAX - CFES_RX_SEVERE_STEP) ? CFES_REC_MAX
                                                                           : rec_ff + CFES_RX_SEVERE_STEP;
                end else begin
                    nxt_rec = (rec_ff == CFES_REC_MAX) ? CFES_REC_MAX : rec_ff + CFES_RX_ERR_STEP;
                end
            end else if (rx_ok_i) begin
                // above 127 a good frame sets the count to 119
                if (rec_ff >= CFES_PASSIVE_REC) begin
                    nxt_rec = CFES_REC_RELOAD;
                end else if (rec_ff != 8'h00) begin
                    nxt_rec = rec_ff - 8'h01;
                end
            end
        end
        if (nxt_tec >= CFES_BUSOFF_TEC) begin
            nxt_est = CFES_BUS_OFF;
        end else if (nxt_tec >= CFES_PASSIVE_TEC || nxt_rec >= CFES_PASSIVE_REC) begin
            nxt_est = CFES_ERR_PASSIVE;
        end else begin
            nxt_est = CFES_ERR_ACTIVE;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tec_ff <= CFES_TEC_RST;
            rec_ff <= CFES_REC_RST;
            seq_ff <= 8'h00;
            est_ff <= CFES_ERR_ACTIVE;
        end else begin
            tec_ff <= nxt_tec;
            rec_ff <= nxt_rec;
            seq_ff <= nxt_seq;
            est_ff <= nxt_est;
        end
    end

    // frame sequencer
    cfes_state_t st_ff, nxt_st;
    logic [CFES_DESC_W-1:0] desc_ff, nxt_desc;
    logic [3:0] byte_ff, nxt_byte;
    logic fv_ff, nxt_fv, ferr_ff, nxt_ferr;
    logic [3:0] fk_ff, nxt_fk;
    logic [28:0] fval_ff, nxt_fval;
    logic slot_free, d_ide, d_rtr, bad_dlc;
    logic [3:0] d_dlc, in_dlc;
    logic [28:0] d_id;
    logic [63:0] d_pay;

    always_comb begin
        d_ide = desc_ff[CFES_IDE_POS];
        d_rtr = desc_ff[CFES_RTR_POS];
        d_dlc = desc_ff[CFES_DLC_LSB +: CFES_DLC_W];
        d_pay = desc_ff[CFES_PAY_LSB +: 64];
        // standard frames keep only the low 11 id bits
        d_id = d_ide ? desc_ff[CFES_ID_LSB +: CFES_EXT_ID_W]
                     : {18'h0_0000, desc_ff[CFES_ID_LSB +: CFES_STD_ID_W]};
        in_dlc = buf_data[CFES_DLC_LSB +: CFES_DLC_W];
        // no payload count can match dlc above 8, so refuse it
        bad_dlc = (in_dlc > CFES_DLC_MAX);
        slot_free = !fv_ff || field_ready_i;
        buf_ready = (st_ff == CFES_ST_IDLE) && (est_ff != CFES_BUS_OFF);
        // predicts the buffer's not-full flag after this edge, so ready leaves a flop
        nxt_req_ready = !((!buf_in_ready && !(buf_ready && buf_valid))
                          || (buf_in_ready && buf_valid && buf_push_valid && !(buf_ready && buf_valid)));
        nxt_st = st_ff;
        nxt_desc = desc_ff;
        nxt_byte = byte_ff;
        nxt_fv = fv_ff && !field_ready_i;
        nxt_fk = fk_ff;
        nxt_fval = fval_ff;
        nxt_ferr = 1'b0;
        if (est_ff == CFES_BUS_OFF) begin
            nxt_st = CFES_ST_IDLE;
            nxt_fv = 1'b0;
        end else begin
            case (st_ff)
                CFES_ST_IDLE: begin
                    if (buf_ready && buf_valid) begin
                        nxt_desc = buf_data;
                        nxt_byte = 4'h0;
                        if (bad_dlc) begin
                            nxt_ferr = 1'b1;
                        end else begin
                            nxt_st = CFES_ST_SOF;
                        end
                    end
                end
                CFES_ST_SOF: if (slot_free) begin
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_SOF;
                    nxt_fval = 29'h0000_0000;
                    nxt_st = CFES_ST_ARB;
                end
                CFES_ST_ARB: if (slot_free) begin
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_ARB;
                    nxt_fval = d_id;
                    nxt_st = CFES_ST_RTR;
                end
                CFES_ST_RTR: if (slot_free) begin
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_RTR;
                    nxt_fval = {28'h000_0000, d_rtr};
                    nxt_st = CFES_ST_IDE;
                end
                CFES_ST_IDE: if (slot_free) begin
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_IDE;
                    nxt_fval = {28'h000_0000, d_ide};
                    nxt_st = CFES_ST_DLC;
                end
                CFES_ST_DLC: if (slot_free) begin
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_DLC;
                    nxt_fval = {25'h000_0000, d_dlc};
                    // remote frames carry no bytes
                    nxt_st = (d_rtr || d_dlc == 4'h0) ? CFES_ST_CRC : CFES_ST_DATA;
                end
                CFES_ST_DATA: if (slot_free) begin
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_DATA;
                    nxt_fval = {21'h00_0000, d_pay[{byte_ff[2:0], 3'h0} +: 8]};
                    nxt_byte = byte_ff + 4'h1;
                    if (byte_ff + 4'h1 == d_dlc) begin
                        nxt_st = CFES_ST_CRC;
                    end
                end
                CFES_ST_CRC: if (slot_free) begin
                    // checksum is filled in by the bit stage downstream
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_CRC;
                    nxt_fval = 29'h0000_0000;
                    nxt_st = CFES_ST_EOF;
                end
                CFES_ST_EOF: if (slot_free) begin
                    nxt_fv = 1'b1;
                    nxt_fk = CFES_FLD_EOF;
                    nxt_fval = 29'h0000_0000;
                    nxt_st = CFES_ST_IDLE;
                end
                default: begin
                    nxt_st = CFES_ST_IDLE;
                    nxt_fv = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= CFES_ST_IDLE;
            desc_ff <= '0;
            byte_ff <= 4'h0;
            fv_ff <= 1'b0;
            fk_ff <= 4'h0;
            fval_ff <= 29'h0000_0000;
            ferr_ff <= 1'b0;
            req_ready_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            desc_ff <= nxt_desc;
            byte_ff <= nxt_byte;
            fv_ff <= nxt_fv;
            fk_ff <= nxt_fk;
            fval_ff <= nxt_fval;
            ferr_ff <= nxt_ferr;
            req_ready_ff <= nxt_req_ready;
        end
    end

    // low for one edge after reset while the prediction settles
    assign req_ready_o = req_ready_ff;
    assign field_valid_o = fv_ff;
    assign field_kind_o = fk_ff;
    assign field_val_o = fval_ff;
    assign frame_err_o = ferr_ff;
    assign err_state_o = est_ff;
    assign tec_o = tec_ff;
    assign rec_o = rec_ff;
endmodule : cfes_node
`default_nettype wire

//--- verification/cfes_node_asserts.sv
// port assertions for the frame sequencer and error state block
// assumes a bind onto cfes_node, single clock mclk_i
`timescale 1ns/1ps
`default_nettype none
module cfes_node_chk
    import cfes_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic field_valid_o,
    input wire logic field_ready_i,
    input wire logic [3:0] field_kind_o,
    input wire logic [28:0] field_val_o,
    input wire logic tx_err_i,
    input wire logic tx_ok_i,
    input wire logic rx_err_i,
    input wire logic rx_err_severe_i,
    input wire logic rx_ok_i,
    input wire logic [1:0] err_state_o,
    input wire logic [8:0] tec_o,
    input wire logic [7:0] rec_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire live = err_state_o != CFES_BUS_OFF;
    function automatic logic [7:0] sat8(input logic [7:0] a, input logic [7:0] b);
        return (a > 8'hff - b) ? 8'hff : a + b;
    endfunction : sat8
    sequence s_take(logic [3:0] k);
        field_valid_o && field_ready_i && field_kind_o == k && live;
    endsequence
    property p_arb_first;
        s_take(CFES_FLD_SOF) |=> field_valid_o && field_kind_o == CFES_FLD_ARB;
    endproperty
    a_arb_first: assert property (p_arb_first) else $error("id not first after sof");
    property p_rtr_next;
        s_take(CFES_FLD_ARB) |=> field_valid_o && field_kind_o == CFES_FLD_RTR;
    endproperty
    a_rtr_next: assert property (p_rtr_next) else $error("rtr not after id");
    property p_hold;
        field_valid_o && !field_ready_i && live |=> field_valid_o && $stable(field_kind_o) && $stable(field_val_o);
    endproperty
    a_hold: assert property (p_hold) else $error("field changed while stalled");
    property p_state;
        live |-> (err_state_o == CFES_ERR_ACTIVE) == (tec_o < 9'h080 && rec_o < 8'h80);
    endproperty
    a_state: assert property (p_state) else $error("state disagrees with counters");
    property p_boff;
        tec_o >= CFES_BUSOFF_TEC |-> !live;
    endproperty
    a_boff: assert property (p_boff) else $error("no bus off above 255");
    property p_quiet;
        (!live) [*2] |-> !field_valid_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("field sent in bus off");
    property p_tec_up;
        tx_err_i && live |=> tec_o == ($past(tec_o) > 9'h1f7 ? 9'h1ff : $past(tec_o) + 9'h008);
    endproperty
    a_tec_up: assert property (p_tec_up) else $error("tec step on error wrong");
    property p_tec_down;
        tx_ok_i && !tx_err_i && live |=> tec_o == $past(tec_o) - {8'h00, |$past(tec_o)};
    endproperty
    a_tec_down: assert property (p_tec_down) else $error("tec step on success wrong");
    property p_rec_up;
        rx_err_i && live |=> rec_o == sat8($past(rec_o), $past(rx_err_severe_i) ? 8'h08 : 8'h01);
    endproperty
    a_rec_up: assert property (p_rec_up) else $error("rec step on error wrong");
    property p_rec_ok;
        rx_ok_i && !rx_err_i && live |=> rec_o == ($past(rec_o) > 8'h7f ? CFES_REC_RELOAD : $past(rec_o) - {7'h00, |$past(rec_o)});
    endproperty
    a_rec_ok: assert property (p_rec_ok) else $error("rec step on success wrong");
endmodule : cfes_node_chk
`default_nettype wire

//--- verification/cfes_sink.sv
// far side of the field stream: takes fields, stalls when asked
// assumes fields from cfes_node on mclk_i; the bench reads got
`timescale 1ns/1ps
`default_nettype none
module cfes_sink (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic field_valid_i,
    input wire logic [3:0] field_kind_i,
    input wire logic [28:0] field_val_i,
    output logic field_ready_o
);
    logic [32:0] got[$];
    logic [7:0] lfsr_ff;
    // shift register stalls so ready also drops mid-frame
    assign field_ready_o = !slow_i || lfsr_ff[0];
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lfsr_ff <= 8'h01;
        end else begin
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
            if (field_valid_i && field_ready_o) got.push_back({field_kind_i, field_val_i});
        end
    end
endmodule : cfes_sink
`default_nettype wire

//--- verification/cfes_node_test.sv
// self-checking bench of the frame sequencer and error state block
// assumes cfes_sink as far side and the checker bound below
`timescale 1ns/1ps
`default_nettype none
module cfes_node_test;
    logic mclk_i = 0, rst_n_i = 0, req_valid_i = 0, req_ide_i = 0, req_rtr_i = 0, slow = 0;
    logic tx_err_i = 0, tx_ok_i = 0, rx_err_i = 0, rx_err_severe_i = 0, rx_ok_i = 0, idle_seq_i = 0;
    logic [28:0] req_id_i = 0;
    logic [3:0] req_dlc_i = 0;
    logic [63:0] req_data_i = 0;
    logic req_ready_o, field_valid_o, field_ready_i, frame_err_o;
    logic [3:0] field_kind_o;
    logic [28:0] field_val_o;
    logic [1:0] err_state_o;
    logic [8:0] tec_o;
    logic [7:0] rec_o;
    logic [31:0] rng = 32'h0000_0004;
    int mismatches = 0, num_checks = 0, nferr = 0, m_tec = 0, m_rec = 0, m_idle = 0, m_boff = 0, n;
    logic [32:0] exp_q[$];
    cfes_node u_dut (.mclk_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_ide_i, .req_id_i, .req_rtr_i,
        .req_dlc_i, .req_data_i, .field_valid_o, .field_ready_i, .field_kind_o, .field_val_o, .frame_err_o,
        .tx_err_i, .tx_ok_i, .rx_err_i, .rx_err_severe_i, .rx_ok_i, .idle_seq_i, .err_state_o, .tec_o, .rec_o);
    cfes_sink u_sink (.mclk_i, .rst_n_i, .slow_i(slow), .field_valid_i(field_valid_o),
        .field_kind_i(field_kind_o), .field_val_i(field_val_o), .field_ready_o(field_ready_i));
    initial forever #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (frame_err_o === 1'b1) nferr++;
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask : tick
    // leaves valid high so back-to-back requests need no idle edge
    task automatic send(input logic ide, input logic [28:0] id, input logic rtr, input logic [3:0] dlc,
        input logic [63:0] d);
        {req_valid_i, req_ide_i, req_id_i, req_rtr_i, req_dlc_i, req_data_i} = {1'b1, ide, id, rtr, dlc, d};
        for (n = 0; n < 500 && req_ready_o !== 1'b1; n++) tick();
        if (n == 500) begin
            mismatches++;
            summarize();
        end
        tick();
        if (dlc > 8) return;
        exp_q.push_back({4'h0, 29'h0});
        exp_q.push_back({4'h1, ide ? id : {18'h0, id[10:0]}});
        exp_q.push_back({4'h3, 28'h0, rtr});
        exp_q.push_back({4'h2, 28'h0, ide});
        exp_q.push_back({4'h4, 25'h0, dlc});
        for (int i = 0; i < dlc && !rtr; i++) exp_q.push_back({4'h5, 21'h0, d[8*i +: 8]});
        exp_q.push_back({4'h6, 29'h0});
        exp_q.push_back({4'h7, 29'h0});
    endtask : send
    task automatic drain();
        for (n = 0; n < 3000 && u_sink.got.size() < exp_q.size(); n++) tick();
        if (n == 3000) begin
            mismatches++;
            summarize();
        end
        check(u_sink.got.size(), exp_q.size());
        foreach (exp_q[i]) check(u_sink.got[i], exp_q[i]);
        exp_q.delete();
        u_sink.got.delete();
    endtask : drain
    function automatic void model();
        if (m_boff) begin
            m_idle += idle_seq_i;
            if (m_idle == 128) {m_boff, m_tec, m_rec} = 0;
        end else begin
            if (tx_err_i) m_tec = m_tec > 503 ? 511 : m_tec + 8;
            else if (tx_ok_i && m_tec > 0) m_tec--;
            if (rx_err_i) m_rec = m_rec + (rx_err_severe_i ? 8 : 1) > 255 ? 255 : m_rec + (rx_err_severe_i ? 8 : 1);
            else if (rx_ok_i) m_rec = m_rec > 127 ? 119 : (m_rec > 0 ? m_rec - 1 : 0);
            m_idle = 0;
            m_boff = m_tec > 255;
        end
    endfunction : model
    // w holds per-event odds out of 16: tx_err, ok, rx_err, severe, idle
    task automatic err_run(input int cyc, input logic [19:0] w);
        logic [31:0] r;
        repeat (cyc) begin
            r = xs();
            {tx_err_i, tx_ok_i, rx_err_i, rx_err_severe_i} = {r[3:0] < w[19:16], r[7:4] < w[15:12],
                r[11:8] < w[11:8], r[15:12] < w[7:4]};
            rx_ok_i = r[19:16] < w[15:12];
            idle_seq_i = r[23:20] < w[3:0];
            model();
            tick();
            check({tec_o, rec_o, err_state_o}, {m_tec[8:0], m_rec[7:0],
                m_boff ? 2'h2 : ((m_tec > 127 || m_rec > 127) ? 2'h1 : 2'h0)});
        end
        {tx_err_i, tx_ok_i, rx_err_i, rx_ok_i, idle_seq_i} = '0;
        tick();
    endtask : err_run
    initial begin
        logic [31:0] r;
        repeat (2) @(posedge mclk_i);
        #1;
        rst_n_i = 1;
        tick();
        check(req_ready_o, 1'b1);
        send(0, 29'h0000_07ff, 0, 0, 0);
        send(1, 29'h1fff_ffff, 0, 8, 64'h0123_4567_89ab_cdef);
        send(1, 29'h0000_0000, 1, 8, 0);
        for (int i = 0; i < 12; i++) begin
            slow = i[0];
            r = xs();
            send(r[0], r[31:3], r[1] & r[2], 4'(xs() % 9), {xs(), xs()});
        end
        req_valid_i = 0;
        drain();
        for (int d = 9; d < 16; d++) send(0, 29'(d), 0, 4'(d), 0);
        req_valid_i = 0;
        for (n = 0; n < 100 && nferr < 7; n++) tick();
        drain();
        check(nferr, 7);
        err_run(30, 20'h00ff0);
        check(err_state_o, 2'h1);
        send(1, 29'h0abc_1234, 0, 2, 64'h0000_0000_0000_a55a);
        req_valid_i = 0;
        drain();
        err_run(200, 20'h33431);
        err_run(60, 20'hf0000);
        check(err_state_o, 2'h2);
        send(0, 29'h0000_0123, 0, 1, 64'h0000_0000_0000_005a);
        send(1, 29'h1234_5678, 1, 3, 0);
        req_valid_i = 0;
        check(req_ready_o, 1'b0);
        err_run(20, 20'h00000);
        check(u_sink.got.size(), 0);
        err_run(300, 20'h0000f);
        drain();
        check(err_state_o, 2'h0);
        summarize();
    end
endmodule : cfes_node_test
bind cfes_node cfes_node_chk u_chk (.mclk_i, .rst_n_i, .field_valid_o, .field_ready_i, .field_kind_o,
    .field_val_o, .tx_err_i, .tx_ok_i, .rx_err_i, .rx_err_severe_i, .rx_ok_i, .err_state_o, .tec_o, .rec_o);
`default_nettype wire
